// *** rtl/sdram_burst_params.svh ***
// Purpose: timing counts, field positions and reset values of the burst logic
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef SDRAM_BURST_PARAMS_SVH
`define SDRAM_BURST_PARAMS_SVH

`define MODE_BL_LSB      0
`define MODE_BL_MSB      2
`define MODE_BT_BIT      3
`define MODE_CL_LSB      4
`define MODE_CL_MSB      6
`define MODE_OP_LOW_BIT  7
`define MODE_OP_HIGH_BIT 8
`define MODE_WB_BIT      9
`define MODE_RESET       12'h000
`define BL_CODE_1        3'h0
`define BL_CODE_2        3'h1
`define BL_CODE_4        3'h2
`define BL_CODE_8        3'h3
`define BL_CODE_PAGE     3'h7
`define CL_CODE_2        3'h2
`define CL_CODE_3        3'h3
`define AUTOPRE_BIT      10
`define MASK_READ_DELAY  2
`define ROW_RESET        13'h0000
`define REFRESH_ROW_STEP 13'h0001

`endif

// *** rtl/sdram_burst_pkg.sv ***
// Purpose: types shared by the burst logic
// Assumes: nothing
// Notes:   constants live in sdram_burst_params.svh
package sdram_burst_pkg;
  typedef enum logic [3:0] {
    cmd_inhibit, cmd_nop, cmd_terminate, cmd_activate, cmd_read,
    cmd_write, cmd_precharge, cmd_refresh, cmd_load_mode
  } command_e;
  typedef enum logic [1:0] {
    op_idle, op_read, op_write, op_self_refresh
  } op_state_e;
endpackage : sdram_burst_pkg

// *** rtl/burst_column_gen.sv ***
// Purpose: column of one burst beat from start, length and type
// Assumes: page_cols is 512 or 1024
// Notes:   purely combinational
`timescale 1ns/1ps
module burst_column_gen
  import sdram_burst_pkg::*;
(
  input  wire logic [9:0] start_col,
  input  wire logic [9:0] beat,
  input  wire logic [2:0] len_code,
  input  wire logic       interleave,
  input  wire logic       page_1k,
  output logic      [9:0] column
);
`include "sdram_burst_params.svh"
  wire [9:0] low_mask  = (len_code == `BL_CODE_2) ? 10'h001 :
                         (len_code == `BL_CODE_4) ? 10'h003 :
                         (len_code == `BL_CODE_8) ? 10'h007 : 10'h000;
  wire [9:0] seq_sum   = start_col + beat;
  wire [9:0] seq_col   = (start_col & ~low_mask) | (seq_sum & low_mask);
  wire [9:0] ilv_col   = (start_col & ~low_mask) | ((start_col ^ beat) & low_mask);
  wire [9:0] page_mask = page_1k ? 10'h3ff : 10'h1ff;
  wire [9:0] page_col  = seq_sum & page_mask;
  // burst of one or unknown code: the addressed column only, type ignored
  assign column = (len_code == `BL_CODE_PAGE) ? page_col :
                  (low_mask == 10'h000)       ? start_col :
                  interleave                  ? ilv_col : seq_col;
endmodule : burst_column_gen

// *** rtl/sdram_command_burst_logic.sv ***
// Purpose: command decode, mode word, burst addressing and read latency
// Assumes: controller keeps clock enable high except for self refresh
// Notes:   storage array is reached through a column/bank/row port
`timescale 1ns/1ps
module sdram_command_burst_logic
  import sdram_burst_pkg::*;
#(
  parameter logic PAGE_1K = 1'b1
)(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        clock_enable,
  input  wire logic        select_n,
  input  wire logic        row_strobe_n,
  input  wire logic        col_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic [12:0] address,
  input  wire logic        bank_select_bit0,
  input  wire logic        bank_select_bit1,
  input  wire logic [3:0]  byte_mask,
  input  wire logic [31:0] data_in,
  output logic      [31:0] data_out,
  output logic      [3:0]  data_out_en,
  input  wire logic [31:0] array_rdata,
  output logic      [1:0]  array_bank,
  output logic      [12:0] array_row,
  output logic      [9:0]  array_col,
  output logic             array_read,
  output logic      [3:0]  array_write_en,
  output logic      [31:0] array_wdata,
  output logic             refresh_pulse,
  output logic      [12:0] refresh_row,
  output logic             self_refresh,
  output logic      [3:0]  bank_open,
  output logic      [11:0] mode_word
);
`include "sdram_burst_params.svh"

  // ---------------------------------------------------------------
  // input capture
  // ---------------------------------------------------------------
  // pins come from the controller's domain: two stages before use
  logic [23:0] pin_meta_reg;
  logic [23:0] pin_sync_reg;
  logic [31:0] din_meta_reg;
  logic [31:0] din_sync_reg;
  wire  [23:0] pin_raw = {clock_enable, select_n, row_strobe_n, col_strobe_n, write_strobe_n,
                          address, bank_select_bit1, bank_select_bit0, byte_mask};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_meta_reg <= 24'hf00000;
      pin_sync_reg <= 24'hf00000;
      din_meta_reg <= 32'h0;
      din_sync_reg <= 32'h0;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      din_meta_reg <= data_in;
      din_sync_reg <= din_meta_reg;
    end
  end

  wire        cke_s  = pin_sync_reg[23];
  wire [3:0]  strb_s = pin_sync_reg[22:19];
  wire [12:0] addr_s = pin_sync_reg[18:6];
  wire [1:0]  bank_s = pin_sync_reg[5:4];
  wire [3:0]  mask_s = pin_sync_reg[3:0];

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  command_e cmd;
  assign cmd = strb_s[3]         ? cmd_inhibit :
               (strb_s == 4'h7)  ? cmd_nop :
               (strb_s == 4'h6)  ? cmd_terminate :
               (strb_s == 4'h3)  ? cmd_activate :
               (strb_s == 4'h5)  ? cmd_read :
               (strb_s == 4'h4)  ? cmd_write :
               (strb_s == 4'h2)  ? cmd_precharge :
               (strb_s == 4'h1)  ? cmd_refresh : cmd_load_mode;

  op_state_e state_reg;
  op_state_e state_next;
  wire in_self = (state_reg == op_self_refresh);
  wire do_auto_refresh = !in_self && (cmd == cmd_refresh) && cke_s;
  wire do_self_entry   = !in_self && (cmd == cmd_refresh) && !cke_s;
  wire accept          = !in_self && cke_s;

  // ---------------------------------------------------------------
  // mode word
  // ---------------------------------------------------------------
  logic [11:0] mode_reg;
  wire  [2:0]  cl_field = addr_s[`MODE_CL_MSB:`MODE_CL_LSB];
  wire  [2:0]  bl_field = addr_s[`MODE_BL_MSB:`MODE_BL_LSB];
  wire cl_ok  = (cl_field == `CL_CODE_2) || (cl_field == `CL_CODE_3);
  wire bl_ok  = (bl_field <= `BL_CODE_8) ||
                ((bl_field == `BL_CODE_PAGE) && !addr_s[`MODE_BT_BIT]);
  wire load_ok = accept && (cmd == cmd_load_mode) && cl_ok && bl_ok;

  always_ff @(posedge clock) begin
    if (sys_rst)
      mode_reg <= `MODE_RESET;
    else if (load_ok)
      mode_reg <= addr_s[11:0];
  end
  assign mode_word = mode_reg;

  wire [2:0] mode_bl  = mode_reg[`MODE_BL_MSB:`MODE_BL_LSB];
  wire       mode_bt  = mode_reg[`MODE_BT_BIT];
  wire       mode_wb  = mode_reg[`MODE_WB_BIT];
  wire [1:0] mode_lat = (mode_reg[`MODE_CL_MSB:`MODE_CL_LSB] == `CL_CODE_3) ? 2'h3 : 2'h2;

  // ---------------------------------------------------------------
  // bank rows
  // ---------------------------------------------------------------
  logic [12:0] open_row_reg [4];
  logic [3:0]  bank_open_reg;
  wire  [12:0] row_in = PAGE_1K ? addr_s : {1'b0, addr_s[11:0]};
  wire         is_act = accept && (cmd == cmd_activate);
  wire         is_pre = accept && (cmd == cmd_precharge);
  wire  [3:0]  bank_dec = 4'h1 << bank_s;

  // ---------------------------------------------------------------
  // burst engine
  // ---------------------------------------------------------------
  logic [9:0] start_reg;
  logic [9:0] beat_reg;
  logic [9:0] left_reg;
  logic [1:0] burst_bank_reg;
  logic       auto_pre_reg;
  logic [2:0] len_reg;
  wire  [9:0] col_now;
  wire  [9:0] page_len = PAGE_1K ? 10'h3ff : 10'h1ff;
  wire  [9:0] bl_beats = (mode_bl == `BL_CODE_2) ? 10'h001 :
                         (mode_bl == `BL_CODE_4) ? 10'h003 :
                         (mode_bl == `BL_CODE_8) ? 10'h007 :
                         (mode_bl == `BL_CODE_PAGE) ? page_len : 10'h000;
  wire is_rd = accept && (cmd == cmd_read);
  wire is_wr = accept && (cmd == cmd_write);
  wire new_burst = is_rd || is_wr;
  wire [2:0] len_now = (is_wr && mode_wb) ? `BL_CODE_1 : mode_bl;
  wire [9:0] left_now = (is_wr && mode_wb) ? 10'h000 : bl_beats;
  wire bursting = (state_reg == op_read) || (state_reg == op_write);
  wire last_beat = bursting && (left_reg == 10'h000);
  wire stop = bursting && (last_beat || (accept && (cmd == cmd_terminate)));
  // full page never ends by itself; it wraps until terminated
  wire page_run = (len_reg == `BL_CODE_PAGE);
  wire finish = stop && !(page_run && last_beat && !(accept && (cmd == cmd_terminate)));

  burst_column_gen u_colgen (
    .start_col  (start_reg),
    .beat       (beat_reg),
    .len_code   (len_reg),
    .interleave (mode_bt),
    .page_1k    (PAGE_1K),
    .column     (col_now)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      op_idle, op_read, op_write: begin
        if (finish)
          state_next = op_idle;
        if (new_burst)
          state_next = is_rd ? op_read : op_write;
        else if (do_self_entry)
          state_next = op_self_refresh;
      end
      op_self_refresh: begin
        if (cke_s)
          state_next = op_idle;
      end
      default: state_next = op_idle;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg      <= op_idle;
      start_reg      <= 10'h0;
      beat_reg       <= 10'h0;
      left_reg       <= 10'h0;
      burst_bank_reg <= 2'h0;
      auto_pre_reg   <= 1'b0;
      len_reg        <= `BL_CODE_1;
    end else begin
      state_reg <= state_next;
      if (new_burst) begin
        start_reg      <= addr_s[9:0] & page_len;
        beat_reg       <= 10'h0;
        left_reg       <= left_now;
        burst_bank_reg <= bank_s;
        auto_pre_reg   <= addr_s[`AUTOPRE_BIT];
        len_reg        <= len_now;
      end else if (bursting) begin
        beat_reg <= beat_reg + 10'h001;
        left_reg <= last_beat ? page_len : left_reg - 10'h001;
      end
    end
  end

  wire close_auto = finish && auto_pre_reg;
  // sets and clears merge so an auto close never hides behind a command
  wire [3:0] auto_clr = close_auto ? (4'h1 << burst_bank_reg) : 4'h0;
  wire [3:0] pre_clr  = !is_pre ? 4'h0 : (addr_s[`AUTOPRE_BIT] ? 4'hf : bank_dec);
  wire [3:0] act_set  = is_act ? bank_dec : 4'h0;
  always_ff @(posedge clock) begin
    if (sys_rst)
      bank_open_reg <= 4'h0;
    else
      bank_open_reg <= (bank_open_reg & ~auto_clr & ~pre_clr) | act_set;
  end
  always_ff @(posedge clock) begin
    if (is_act)
      open_row_reg[bank_s] <= row_in;
  end
  assign bank_open = bank_open_reg;

  // ---------------------------------------------------------------
  // refresh
  // ---------------------------------------------------------------
  logic [12:0] refresh_row_reg;
  logic        refresh_pulse_reg;
  wire  [12:0] row_wrap = PAGE_1K ? 13'h1fff : 13'h0fff;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      refresh_row_reg   <= `ROW_RESET;
      refresh_pulse_reg <= 1'b0;
    end else begin
      refresh_pulse_reg <= do_auto_refresh || in_self;
      if (do_auto_refresh || in_self)
        refresh_row_reg <= (refresh_row_reg + `REFRESH_ROW_STEP) & row_wrap;
    end
  end
  assign refresh_pulse = refresh_pulse_reg;
  assign refresh_row   = refresh_row_reg;
  assign self_refresh  = in_self;

  // ---------------------------------------------------------------
  // array access and read pipeline
  // ---------------------------------------------------------------
  wire rd_beat = (state_reg == op_read);
  wire wr_beat = (state_reg == op_write);
  logic [3:0]  mask_d1_reg;
  logic [3:0]  mask_d2_reg;
  // write data and mask come with the command: one stage more lines them up with beat 0
  logic [31:0] wdata_d1_reg;
  always_ff @(posedge clock) begin
    wdata_d1_reg <= din_sync_reg;
  end
  assign array_bank     = burst_bank_reg;
  assign array_row      = open_row_reg[burst_bank_reg];
  assign array_col      = col_now;
  assign array_read     = rd_beat;
  assign array_write_en = wr_beat ? ~mask_d1_reg : 4'h0;
  assign array_wdata    = wdata_d1_reg;

  // command at stage 0; data drive starts lat edges later
  logic [31:0] rd_pipe_reg [3];
  logic [2:0]  rd_vld_reg;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_vld_reg  <= 3'h0;
      mask_d1_reg <= 4'hf;
      mask_d2_reg <= 4'hf;
    end else begin
      rd_vld_reg  <= {rd_vld_reg[1:0], rd_beat};
      mask_d1_reg <= mask_s;
      mask_d2_reg <= mask_d1_reg;
    end
  end
  always_ff @(posedge clock) begin
    rd_pipe_reg[0] <= array_rdata;
    rd_pipe_reg[1] <= rd_pipe_reg[0];
    rd_pipe_reg[2] <= rd_pipe_reg[1];
  end

  // beat fetched at edge n+1 (first cycle after command capture)
  wire        out_vld  = (mode_lat == 2'h3) ? rd_vld_reg[1] : rd_vld_reg[0];
  wire [31:0] out_data = (mode_lat == 2'h3) ? rd_pipe_reg[1] : rd_pipe_reg[0];
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      data_out    <= 32'h0;
      data_out_en <= 4'h0;
    end else begin
      data_out    <= out_data;
      data_out_en <= out_vld ? ~mask_d2_reg : 4'h0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_LATENCY_OK: assert property (@(posedge clock) disable iff (sys_rst)
    (mode_reg[6:4] == 3'h2) || (mode_reg[6:4] == 3'h3) || (mode_reg == `MODE_RESET))
    else $error("latency field holds reserved code");
  AST_SINGLE_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
    is_wr && mode_wb |=> wr_beat ##1 (!wr_beat || $past(new_burst)))
    else $error("single write lasted more than one beat");
  AST_PRE_ALL: assert property (@(posedge clock) disable iff (sys_rst)
    is_pre && addr_s[10] |=> bank_open_reg == 4'h0)
    else $error("precharge all left a bank open");
  AST_ACT_OPEN: assert property (@(posedge clock) disable iff (sys_rst)
    is_act |=> bank_open_reg[$past(bank_s)])
    else $error("activate did not open bank");
  AST_SELF_ENTRY: assert property (@(posedge clock) disable iff (sys_rst)
    do_self_entry && !new_burst |=> self_refresh)
    else $error("self refresh not entered");
  AST_AUTO_REF: assert property (@(posedge clock) disable iff (sys_rst)
    do_auto_refresh |=> refresh_pulse && refresh_row == (($past(refresh_row) + 13'h0001) & row_wrap))
    else $error("refresh counter did not step");
  AST_BL1_COL: assert property (@(posedge clock) disable iff (sys_rst)
    bursting && len_reg == `BL_CODE_1 |-> array_col == start_reg)
    else $error("length one accessed wrong column");
  AST_READ_LAT: assert property (@(posedge clock) disable iff (sys_rst)
    rd_beat && !$past(rd_beat) && mode_lat == 2'h2 && !load_ok ##1 !load_ok |=> data_out_en == ~$past(mask_d2_reg))
    else $error("read data not driven at latency two");
  AST_WRITE_MASK: assert property (@(posedge clock) disable iff (sys_rst)
    wr_beat |-> array_write_en == ~$past(mask_s))
    else $error("write mask not applied at zero delay");
  AST_SEQ_WRAP: assert property (@(posedge clock) disable iff (sys_rst)
    bursting && len_reg == `BL_CODE_4 && !mode_bt |-> array_col[9:2] == start_reg[9:2])
    else $error("sequential burst left its block");
endmodule : sdram_command_burst_logic

// *** testbench/mem_ctrl_model.sv ***
// Purpose: controller side of the command pins, one command per call
// Assumes: pins change by non-blocking assignment after a rising edge
// Notes:   address, bank and data lines after a command show the inverse of their last value; strobes return to no operation
`timescale 1ns/1ps
module mem_ctrl_model (
  input  wire logic        clock,
  output logic             clock_enable,
  output logic             select_n,
  output logic             row_strobe_n,
  output logic             col_strobe_n,
  output logic             write_strobe_n,
  output logic      [12:0] address,
  output logic             bank_select_bit0,
  output logic             bank_select_bit1,
  output logic      [3:0]  byte_mask,
  output logic      [31:0] data_in
);
  initial begin
    clock_enable = 1'b1;
    select_n = 1'b1;
    {row_strobe_n, col_strobe_n, write_strobe_n} = 3'h7;
    address = 13'h0000;
    {bank_select_bit1, bank_select_bit0} = 2'h0;
    byte_mask = 4'h0;
    data_in = 32'h00000000;
  end

  // one cycle of command, then no operation
  task automatic issue(input logic sel, input logic [2:0] rcw, input logic [12:0] a, input logic [1:0] ba,
                       input logic [31:0] d);
    @(posedge clock);
    select_n <= sel;
    {row_strobe_n, col_strobe_n, write_strobe_n} <= rcw;
    address <= a;
    {bank_select_bit1, bank_select_bit0} <= ba;
    data_in <= d;
    @(posedge clock);
    select_n <= 1'b0;
    {row_strobe_n, col_strobe_n, write_strobe_n} <= 3'h7;
    address <= ~a;
    {bank_select_bit1, bank_select_bit0} <= ~ba;
    data_in <= ~d;
  endtask : issue

  task automatic set_mask(input logic [3:0] m);
    @(posedge clock);
    byte_mask <= m;
  endtask : set_mask

  // low only from self refresh entry until exit
  task automatic set_cke(input logic v);
    @(posedge clock);
    clock_enable <= v;
  endtask : set_cke
endmodule : mem_ctrl_model

// *** testbench/tb_sdram_command_burst_logic.sv ***
// Purpose: self-checking bench for command decode and burst addressing
// Assumes: default 1024-column page, array model returns row, bank and column as data
// Notes:   burst orders run from a table; the rest are hand tests
`timescale 1ns/1ps
module tb_sdram_command_burst_logic;
  localparam logic [2:0] ACT = 3'h3, RD = 3'h5, WR = 3'h4, TERM = 3'h6, PRE = 3'h2, REF = 3'h1, LMR = 3'h0;
  typedef struct {logic [2:0] lc; logic il; logic [9:0] st; logic [9:0] base; int n; logic [31:0] ord;
                  logic [2:0] lat;} burst_row_s;
  logic        clock, sys_rst, clock_enable, select_n, row_strobe_n, col_strobe_n, write_strobe_n;
  logic        bank_select_bit0, bank_select_bit1, array_read, refresh_pulse, self_refresh;
  logic [12:0] address, array_row, refresh_row, r0;
  logic [3:0]  byte_mask, data_out_en, array_write_en, bank_open, en_first, wen_first;
  logic [31:0] data_in, data_out, array_rdata, array_wdata, dout_first, wdata_first;
  logic [1:0]  array_bank;
  logic [9:0]  array_col, wcol_first;
  logic [11:0] mode_word;
  logic [9:0]  rcols[$];
  logic [12:0] rrows[$];
  int          mismatches, checks, cyc, t_read, t_out, wcount, pulses, i, k;
  logic [11:0] bad_words[5] = '{12'h012, 12'h042, 12'h024, 12'h026, 12'h02f};
  burst_row_s  rows[8] = '{
    '{3'h0, 1'b1, 10'h2a5, 10'h2a5, 1, 32'h0, 3'h2}, '{3'h1, 1'b0, 10'h0c1, 10'h0c0, 2, 32'h10000000, 3'h3},
    '{3'h2, 1'b0, 10'h101, 10'h100, 4, 32'h12300000, 3'h2}, '{3'h2, 1'b1, 10'h101, 10'h100, 4, 32'h10320000, 3'h3},
    '{3'h3, 1'b0, 10'h0f5, 10'h0f0, 8, 32'h56701234, 3'h2}, '{3'h3, 1'b1, 10'h0f5, 10'h0f0, 8, 32'h54761032, 3'h3},
    '{3'h3, 1'b1, 10'h0f3, 10'h0f0, 8, 32'h32107654, 3'h2}, '{3'h3, 1'b1, 10'h0f6, 10'h0f0, 8, 32'h67452301, 3'h3}};

  // 40 MHz suits either latency
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  assign array_rdata = {array_row[11:0], array_bank, 8'h00, array_col};

  mem_ctrl_model mem_ctrl_model_i (.clock, .clock_enable, .select_n, .row_strobe_n, .col_strobe_n,
    .write_strobe_n, .address, .bank_select_bit0, .bank_select_bit1, .byte_mask, .data_in);
  sdram_command_burst_logic sdram_command_burst_logic_i (.clock, .sys_rst, .clock_enable,
    .select_n, .row_strobe_n, .col_strobe_n, .write_strobe_n, .address, .bank_select_bit0, .bank_select_bit1,
    .byte_mask, .data_in, .data_out, .data_out_en, .array_rdata, .array_bank, .array_row, .array_col,
    .array_read, .array_write_en, .array_wdata, .refresh_pulse, .refresh_row, .self_refresh, .bank_open,
    .mode_word);

  // --------------------------------------------------------------
  // monitor of the array port and read outputs
  // --------------------------------------------------------------
  always @(posedge clock) begin
    cyc++;
    if (array_read === 1'b1) begin
      if (t_read < 0) t_read = cyc;
      rcols.push_back(array_col);
      rrows.push_back(array_row);
    end
    if (data_out_en !== 4'h0 && t_out < 0) begin
      t_out = cyc;
      dout_first = data_out;
      en_first = data_out_en;
    end
    if (array_write_en !== 4'h0) begin
      if (wcount == 0) {wen_first, wdata_first, wcol_first} = {array_write_en, array_wdata, array_col};
      wcount++;
    end
    if (refresh_pulse === 1'b1) pulses++;
  end

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  task automatic run(input int n);
    repeat (n) @(posedge clock);
  endtask : run

  task automatic cmd(input logic [2:0] rcw, input logic [12:0] a, input logic [1:0] ba, input logic [31:0] d);
    mem_ctrl_model_i.issue(1'b0, rcw, a, ba, d);
    run(3);
  endtask : cmd

  // normal operating mode, top address bit low
  task automatic load(input logic [11:0] mw);
    cmd(LMR, {1'b0, mw}, 2'h0, 32'h0);
    cmd(PRE, 13'h0400, 2'h0, 32'h0);
  endtask : load

  task automatic clear();
    {t_read, t_out, wcount, pulses} = {-32'sd1, -32'sd1, 32'd0, 32'd0};
    rcols.delete();
    rrows.delete();
  endtask : clear

  task automatic wait_self(input logic v);
    for (i = 0; i < 20 && self_refresh !== v; i++) run(1);
    check("self_refresh", 32'(self_refresh), 32'(v));
    if (self_refresh !== v) print_verdict();
  endtask : wait_self

  initial begin
    {cyc, mismatches, checks} = '0;
    clear();
    sys_rst = 1'b1;
    run(20);
    sys_rst <= 1'b0;
    run(3);
    check("mode_word_reset", 32'(mode_word), 32'h0);
    check("bank_open_reset", 32'(bank_open), 32'h0);
    check("data_out_en_reset", 32'(data_out_en), 32'h0);
    check("self_refresh_reset", 32'(self_refresh), 32'h0);
    for (i = 0; i < 8; i++) begin
      load({5'h00, rows[i].lat, rows[i].il, rows[i].lc});
      check("mode_word", 32'(mode_word), 32'({5'h00, rows[i].lat, rows[i].il, rows[i].lc}));
      cmd(ACT, 13'h1abc, 2'h1, 32'h0);
      clear();
      cmd(RD, {3'h0, rows[i].st}, 2'h1, 32'h0);
      run(14);
      check("beats", 32'(rcols.size()), 32'(rows[i].n));
      for (k = 0; k < rows[i].n; k++)
        check("column", 32'(rcols[k]), 32'(rows[i].base | 10'(rows[i].ord[31-4*k -: 4])));
      check("row", 32'(rrows[0]), 32'h1abc);
      check("latency", 32'(t_out - t_read), 32'(rows[i].lat));
      check("first_data", dout_first, {12'habc, 2'h1, 8'h00, rows[i].st});
    end
    for (i = 0; i < 5; i++) begin
      cmd(LMR, {1'b0, bad_words[i]}, 2'h0, 32'h0);
      check("mode_refused", 32'(mode_word), 32'h03b);
    end
    load(12'h027);
    cmd(ACT, 13'h0002, 2'h1, 32'h0);
    clear();
    cmd(RD, 13'h03fe, 2'h1, 32'h0);
    cmd(TERM, 13'h0000, 2'h0, 32'h0);
    run(12);
    for (k = 0; k < 4; k++) check("page_column", 32'(rcols[k]), 32'((10'h3fe + k) & 10'h3ff));
    check("page_terminated", 32'(rcols.size()), 32'h5);
    load(12'h022);
    cmd(ACT, 13'h0005, 2'h0, 32'h0);
    mem_ctrl_model_i.set_mask(4'h5);
    clear();
    cmd(WR, 13'h0002, 2'h0, 32'hcafef00d);
    run(12);
    check("write_beats", 32'(wcount), 32'h4);
    check("write_mask", 32'(wen_first), 32'ha);
    check("write_data", wdata_first, 32'hcafef00d);
    check("write_column", 32'(wcol_first), 32'h2);
    load(12'h232);
    check("mode_word_wb", 32'(mode_word), 32'h232);
    cmd(ACT, 13'h0005, 2'h0, 32'h0);
    mem_ctrl_model_i.set_mask(4'h3);
    clear();
    cmd(WR, 13'h0001, 2'h0, 32'h12345678);
    cmd(RD, 13'h0000, 2'h0, 32'h0);
    run(14);
    check("single_write", 32'(wcount), 32'h1);
    check("read_still_bursts", 32'(rcols.size()), 32'h4);
    check("read_mask", 32'(en_first), 32'hc);
    mem_ctrl_model_i.set_mask(4'h0);
    load(12'h022);
    cmd(ACT, 13'h0007, 2'h3, 32'h0);
    check("bank_opened", 32'(bank_open), 32'h8);
    cmd(RD, 13'h0404, 2'h3, 32'h0);
    run(12);
    check("auto_precharge", 32'(bank_open), 32'h0);
    cmd(ACT, 13'h0001, 2'h2, 32'h0);
    cmd(ACT, 13'h0001, 2'h1, 32'h0);
    cmd(PRE, 13'h0000, 2'h2, 32'h0);
    check("precharge_one", 32'(bank_open), 32'h2);
    cmd(PRE, 13'h0400, 2'h2, 32'h0);
    check("precharge_all", 32'(bank_open), 32'h0);
    mem_ctrl_model_i.issue(1'b1, ACT, 13'h0010, 2'h2, 32'h0);
    cmd(3'h7, 13'h0010, 2'h2, 32'h0);
    check("inhibit_nop", 32'(bank_open), 32'h0);
    r0 = refresh_row;
    clear();
    cmd(REF, 13'h1fff, 2'h3, 32'h0);
    run(3);
    check("refresh_pulses", 32'(pulses), 32'h1);
    check("refresh_row", 32'(refresh_row), 32'(r0 + 13'h0001));
    mem_ctrl_model_i.set_cke(1'b0);
    cmd(REF, 13'h0000, 2'h0, 32'h0);
    wait_self(1'b1);
    r0 = refresh_row;
    run(4);
    check("self_refresh_counts", 32'(refresh_row != r0), 32'h1);
    mem_ctrl_model_i.set_cke(1'b1);
    wait_self(1'b0);
    print_verdict();
  end
endmodule : tb_sdram_command_burst_logic
